// ---- design/fbs_sram_port.sv ----
// Write buffer and top level of the flow-through burst SRAM port.
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Small FIFO with valid and ready on both sides
// ---------------------------------------------------------------------
module fbs_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    localparam logic [PW:0] FULL = (PW+1)'(D);
    localparam logic [PW:0] NONE = '0;
    localparam logic [PW:0] ONE = (PW+1)'(1);

    logic [W-1:0] store [D];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic push;
    logic pop;

    // Depth must be a power of two so that the pointers wrap on their own.
    assign in_ready = (cnt != FULL);
    assign out_valid = (cnt != NONE);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = store[rp];

    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            store[wp] <= in_data;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge clk) begin
        if (srst) begin
            wp <= '0;
            rp <= '0;
            cnt <= NONE;
        end else begin
            if (push) begin
                wp <= wp + PW'(1);
            end
            if (pop) begin
                rp <= rp + PW'(1);
            end
            if (push && !pop) begin
                cnt <= cnt + ONE;
            end else if (pop && !push) begin
                cnt <= cnt - ONE;
            end
        end
    end
endmodule

// ---------------------------------------------------------------------
// Device logic of the burst SRAM
// ---------------------------------------------------------------------
module fbs_sram_port
    import fbs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Access control
    input wire logic clock_gate_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic select_a_n,
    input wire logic select_b,
    input wire logic select_c_n,
    input wire logic write_cmd_n,
    input wire logic advance_or_load,
    input wire logic [LANES-1:0] lane_write_sel_n,
    input wire logic out_drive_n,
    input wire logic burst_order,
    // Data lines
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    // Parity lines
    input wire logic [LANES-1:0] parity_lines_in,
    output logic [LANES-1:0] parity_lines_out,
    output logic parity_lines_oe,
    // Write buffer status
    output logic write_buf_ready
);
    fbs_op_t op;
    fbs_op_t next_op;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] next_base;
    logic [BURST_W-1:0] cnt;
    logic [BURST_W-1:0] next_cnt;
    logic [ADDR_W-1:0] next_addr;
    logic sel;
    logic order_s1;
    logic order_s2;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic push_valid;
    logic [ENTRY_W-1:0] push_data;
    logic head_valid;
    logic [ENTRY_W-1:0] head;
    logic [ADDR_W-1:0] head_addr;
    logic drain;
    logic [SLICE_W-1:0] lane_q [LANES];

    // -----------------------------------------------------------------
    // Selection and next access
    // -----------------------------------------------------------------

    // All three selects must agree; any other mix deselects.
    assign sel = !select_a_n && select_b && !select_c_n;

    // Load on advance low, otherwise step a running burst.
    always_comb begin
        next_op = op;
        next_base = base;
        next_cnt = cnt;
        if (!advance_or_load) begin
            next_base = addr;
            next_cnt = BURST_FIRST;
            if (!sel) begin
                next_op = FBS_IDLE;
            end else if (!write_cmd_n) begin
                next_op = FBS_WRITE;
            end else begin
                next_op = FBS_READ;
            end
        end else if (op != FBS_IDLE) begin
            next_cnt = cnt + BURST_STEP;
        end
    end

    // Only the low bits move, so a burst wraps inside its group.
    always_comb begin
        next_addr = next_base;
        if (order_s2) begin
            next_addr[BURST_W-1:0] = next_base[BURST_W-1:0] ^ next_cnt;
        end else begin
            next_addr[BURST_W-1:0] = next_base[BURST_W-1:0] + next_cnt;
        end
    end

    // -----------------------------------------------------------------
    // Registered state
    // -----------------------------------------------------------------

    // The strap is static but still crosses two flops before use.
    always_ff @(posedge clk) begin
        order_s1 <= burst_order;
        order_s2 <= order_s1;
    end

    // Input registers; a gated edge holds everything and keeps the
    // access alive, so suspension extends the cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            op <= FBS_IDLE;
            base <= ADDR_RESET;
            cnt <= BURST_FIRST;
        end else if (!clock_gate_n) begin
            op <= next_op;
            base <= next_base;
            cnt <= next_cnt;
        end
    end

    // A write access takes its data one enabled clock later.
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend <= 1'b0;
            wr_addr <= ADDR_RESET;
        end else if (!clock_gate_n) begin
            wr_pend <= (next_op == FBS_WRITE);
            wr_addr <= next_addr;
        end
    end

    // -----------------------------------------------------------------
    // Write buffer
    // -----------------------------------------------------------------

    // Entry holds address, parity, data and lane selects.
    assign push_valid = wr_pend && !clock_gate_n;
    assign push_data = {wr_addr, parity_lines_in, data_lines_in, lane_write_sel_n};
    assign drain = !clock_gate_n;
    assign head_addr = head[ENTRY_W-1 -: ADDR_W];

    // Self-timed commit: the buffer drains on its own on enabled edges.
    fbs_fifo #(
        .W(ENTRY_W),
        .D(FIFO_DEPTH)
    ) u_wbuf (
        .clk(clk),
        .srst(srst),
        .in_valid(push_valid),
        .in_ready(write_buf_ready),
        .in_data(push_data),
        .out_valid(head_valid),
        .out_ready(drain),
        .out_data(head)
    );

    // -----------------------------------------------------------------
    // Array lanes, one per byte with its parity bit
    // -----------------------------------------------------------------
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [SLICE_W-1:0] mem [WORDS];
        logic [SLICE_W-1:0] head_slice;
        logic [SLICE_W-1:0] push_slice;
        logic [SLICE_W-1:0] rd;

        assign head_slice = {head[LANES+DATA_W+i], head[LANES+i*LANE_W +: LANE_W]};
        assign push_slice = {parity_lines_in[i], data_lines_in[i*LANE_W +: LANE_W]};

        // Commit a buffered lane only when its select is low.
        always_ff @(posedge clk) begin
            if (head_valid && drain && !head[i]) begin
                mem[head_addr] <= head_slice;
            end
        end

        // Newer pending writes override the array so reads stay coherent.
        always_comb begin
            rd = mem[next_addr];
            if (head_valid && !head[i] && head_addr == next_addr) begin
                rd = head_slice;
            end
            if (push_valid && !lane_write_sel_n[i] && wr_addr == next_addr) begin
                rd = push_slice;
            end
        end

        // Read data is launched at the edge that takes the address.
        always_ff @(posedge clk) begin
            if (srst) begin
                lane_q[i] <= SLICE_RESET;
            end else if (!clock_gate_n && next_op == FBS_READ) begin
                lane_q[i] <= rd;
            end
        end

        assign data_lines_out[i*LANE_W +: LANE_W] = lane_q[i][LANE_W-1:0];
        assign parity_lines_out[i] = lane_q[i][LANE_W];
    end

    // -----------------------------------------------------------------
    // Output drivers
    // -----------------------------------------------------------------

    // Only a read cycle drives; write data phases and deselected cycles
    // are masked, and the enable pin acts combinationally.
    assign data_lines_oe = (op == FBS_READ) && !out_drive_n;
    assign parity_lines_oe = data_lines_oe;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_load_wr;
        !clock_gate_n && !advance_or_load && sel && !write_cmd_n;
    endsequence

    sequence s_load_rd;
        !clock_gate_n && !advance_or_load && sel && write_cmd_n;
    endsequence

    a_gate_hold_state:
    assert property (clock_gate_n |=> $stable(op) && $stable(base) && $stable(cnt))
        else $error("State changed on a gated edge.");

    a_load_new_addr:
    assert property (!clock_gate_n && !advance_or_load && sel
        |=> op != FBS_IDLE && base == $past(addr) && cnt == BURST_FIRST)
        else $error("Load did not take the external address.");

    a_advance_step:
    assert property (!clock_gate_n && advance_or_load && op != FBS_IDLE
        |=> cnt == $past(cnt) + BURST_STEP && $stable(base))
        else $error("Advance did not step the burst counter.");

    a_deselect_mix:
    assert property (!clock_gate_n && !advance_or_load && !sel |=> op == FBS_IDLE)
        else $error("Device stayed selected with a bad select mix.");

    a_write_cmd:
    assert property (s_load_wr |=> op == FBS_WRITE)
        else $error("Write command not taken.");

    a_back_to_back:
    assert property (s_load_wr ##1 s_load_rd |=> op == FBS_READ && !wr_pend ##0 $past(wr_pend))
        else $error("Read after write was not accepted at once.");

    a_write_tristate:
    assert property (op == FBS_WRITE |-> !data_lines_oe && !parity_lines_oe)
        else $error("Drivers on during a write data phase.");

    a_drive_async:
    assert property (out_drive_n || op != FBS_READ |-> !data_lines_oe)
        else $error("Drivers on against the output enable.");

    a_desel_tristate:
    assert property (op == FBS_IDLE |-> !data_lines_oe)
        else $error("Drivers on while deselected.");

    a_write_commit:
    assert property (s_load_wr ##1 !clock_gate_n
        |-> push_valid ##1 head_valid && head_addr == $past(wr_addr))
        else $error("Write data was not buffered for commit.");

endmodule

// ---- design/fbs_pkg.sv ----
// Shared constants and types for the flow-through burst SRAM port.
// Behaviour
// - Register all synchronous inputs on rising edge.
// - Clock gate high holds every internal state; the two order strap flops (order_s1, order_s2) still update on gated edges.
// - New access every enabled clock, no waits.
// - Seventeen-bit address selects one word.
// - Array of 128K words by 36 bits.
// - Write command sampled only on enabled edges.
// - Each lane select gates byte plus parity.
// - Advance high steps the burst counter.
// - Advance low loads external address, new access.
// - Three chip selects decide device selection.
// - Drivers off during write data phase.
// - Output enable acts without the clock.
// - Writes complete by internal self-timed logic.
// - Burst order linear or interleaved supported.
// - Selected only for low, high, low selects.
// - Order strap: high interleaved, low linear.
// - Read data follows in the next cycle.
// - Drivers off while deselected; on again from the first read cycle after it.
package fbs_pkg;

    // -----------------------------------------------------------------
    // Sizes
    // -----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int WORDS = 131072;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int WORD_W = DATA_W + LANES;
    localparam int SLICE_W = LANE_W + 1;
    localparam int BURST_W = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int ENTRY_W = ADDR_W + WORD_W + LANES;

    // -----------------------------------------------------------------
    // Burst counter values and reset values
    // -----------------------------------------------------------------
    localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
    localparam logic [SLICE_W-1:0] SLICE_RESET = 9'h000;

    // -----------------------------------------------------------------
    // Kind of access held in the current cycle
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        FBS_IDLE,
        FBS_READ,
        FBS_WRITE
    } fbs_op_t;

endpackage

// ---- verif/fbs_ctrl_model.sv ----
// Controller model that drives the bus pins of the flow-through burst SRAM port.
`timescale 1ns/1ps
module fbs_ctrl_model
    import fbs_pkg::*;
(
    // Clock and strap
    input wire logic clk,
    input wire logic burst_order,
    // Controls to the port
    output logic clock_gate_n,
    output logic [ADDR_W-1:0] addr,
    output logic select_a_n,
    output logic select_b,
    output logic select_c_n,
    output logic write_cmd_n,
    output logic advance_or_load,
    output logic [LANES-1:0] lane_write_sel_n,
    output logic out_drive_n,
    // Shared data and parity wire
    input wire logic [WORD_W-1:0] port_out,
    input wire logic port_oe,
    output logic [WORD_W-1:0] wire_level
);
    // Access state as the controller tracks it.
    logic [1:0] kind;
    logic [1:0] cnt;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] acc_addr;
    logic pend;
    logic drv;
    logic [LANES-1:0] pend_l;
    logic [WORD_W-1:0] pend_d;
    logic [WORD_W-1:0] drv_d;
    logic [WORD_W-1:0] last = '0;

    // Released lines show the inverse of their last level, so stale data never passes.
    assign wire_level = drv ? drv_d : (port_oe ? port_out : ~last);
    always @(posedge clk) last <= wire_level;

    // Parks the bus: edges gated, nothing driven, no access pending.
    task automatic clear();
        kind = 2'h0;
        pend = 1'b0;
        drv <= 1'b0;
        clock_gate_n <= 1'b1;
        out_drive_n <= 1'b0;
        lane_write_sel_n <= 4'hF;
    endtask

    initial begin
        addr = '0;
        {select_a_n, select_b, select_c_n, write_cmd_n, advance_or_load} = 5'h10;
        clear();
    end

    // One cycle of the bus, launched at the falling edge.
    task automatic step(input bit gate, input bit load, input logic [2:0] sel, input bit wr,
        input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] wd, input logic [LANES-1:0] ln,
        input bit odn);
        @(negedge clk);
        out_drive_n <= odn;
        clock_gate_n <= gate;
        if (gate) begin
            // Ignored edges, so the controls are scrambled meanwhile.
            addr <= ADDR_W'($urandom);
            // Gated edges take no write data, so let go of the lines; a pending write goes in at the next enabled edge.
            drv <= 1'b0;
            lane_write_sel_n <= 4'hF;
            {select_a_n, select_b, select_c_n, write_cmd_n, advance_or_load} <= 5'($urandom);
        end else begin
            addr <= a;
            {select_a_n, select_b, select_c_n} <= sel;
            write_cmd_n <= !wr;
            advance_or_load <= !load;
            drv <= pend;
            drv_d <= pend_d;
            lane_write_sel_n <= pend ? pend_l : 4'hF;
            if (load) begin
                kind = (sel == 3'b010) ? (wr ? 2'h2 : 2'h1) : 2'h0;
                base = a;
                cnt = 2'h0;
            end else if (kind != 2'h0) begin
                cnt = cnt + 2'h1;
            end
            acc_addr = {base[ADDR_W-1:2], burst_order ? base[1:0] ^ cnt : base[1:0] + cnt};
            pend = (kind == 2'h2);
            pend_d = wd;
            pend_l = ln;
        end
    endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking testbench for the flow-through burst SRAM port.
`timescale 1ns/1ps
module tb_top;
    import fbs_pkg::*;
    typedef struct {bit rd; logic [WORD_W-1:0] d;} fbs_exp_t;
    localparam logic [2:0] SEL = 3'b010;
    localparam logic [ADDR_W-1:0] TOP = 17'h1FFF8;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic burst_order = 1'b1;
    logic clock_gate_n, select_a_n, select_b, select_c_n, write_cmd_n, advance_or_load;
    logic out_drive_n, data_lines_oe, parity_lines_oe, write_buf_ready;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_write_sel_n, parity_lines_out;
    logic [DATA_W-1:0] data_lines_out;
    logic [WORD_W-1:0] wire_level;
    logic [WORD_W-1:0] mem [int];
    fbs_exp_t expq [$];
    int num_errors = 0;
    int comparisons = 0;

    initial forever #10 clk = ~clk;

    fbs_sram_port DUT (.clk(clk), .srst(srst), .clock_gate_n(clock_gate_n), .addr(addr),
        .select_a_n(select_a_n), .select_b(select_b), .select_c_n(select_c_n),
        .write_cmd_n(write_cmd_n), .advance_or_load(advance_or_load),
        .lane_write_sel_n(lane_write_sel_n), .out_drive_n(out_drive_n),
        .burst_order(burst_order), .data_lines_in(wire_level[DATA_W-1:0]),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
        .parity_lines_in(wire_level[WORD_W-1:DATA_W]), .parity_lines_out(parity_lines_out),
        .parity_lines_oe(parity_lines_oe), .write_buf_ready(write_buf_ready));

    fbs_ctrl_model p (.clk(clk), .burst_order(burst_order), .clock_gate_n(clock_gate_n),
        .addr(addr), .select_a_n(select_a_n), .select_b(select_b), .select_c_n(select_c_n),
        .write_cmd_n(write_cmd_n), .advance_or_load(advance_or_load),
        .lane_write_sel_n(lane_write_sel_n), .out_drive_n(out_drive_n),
        .port_out({parity_lines_out, data_lines_out}), .port_oe(data_lines_oe),
        .wire_level(wire_level));

    // -----------------------------------------------------------------
    // Checking and closing
    // -----------------------------------------------------------------
    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles; a hang stops here.
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        conclude();
    end

    // Watches each edge and compares against the oldest note.
    initial begin
        fbs_exp_t e;
        logic [WORD_W-1:0] held;
        bit rd_now;
        forever begin
            @(posedge clk);
            if (srst) begin
                held = '0;
                rd_now = 1'b0;
            end else begin
                if (!clock_gate_n) begin
                    e = expq.pop_front();
                    rd_now = e.rd;
                    if (e.rd) held = e.d;
                end
                @(negedge clk);
                #1;
                check({parity_lines_out, data_lines_out}, held);
                check({35'h0, data_lines_oe}, {35'h0, rd_now & !out_drive_n});
                check({35'h0, parity_lines_oe}, {35'h0, rd_now & !out_drive_n});
                check({35'h0, write_buf_ready}, 36'h1);
            end
        end
    end

    // -----------------------------------------------------------------
    // Stimulus
    // -----------------------------------------------------------------
    // One bus cycle with fresh random data; the expected result is noted at once.
    task automatic op(input bit gate, input bit load, input logic [2:0] sel, input bit wr,
        input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln);
        logic [WORD_W-1:0] wd;
        wd = WORD_W'({$urandom, $urandom});
        p.step(gate, load, sel, wr, a, wd, ln, $urandom_range(0, 3) == 0);
        if (!gate) begin
            for (int i = 0; i < LANES && p.kind == 2'h2; i++) begin
                if (!ln[i]) begin
                    mem[p.acc_addr][8*i +: 8] = wd[8*i +: 8];
                    mem[p.acc_addr][DATA_W+i] = wd[DATA_W+i];
                end
            end
            expq.push_back('{p.kind == 2'h1, (p.kind == 2'h1) ? mem[p.acc_addr] : '0});
        end
    endtask

    // Reset with the strap set; the strap only changes here, as it must stay static.
    task automatic restart(input bit order);
        @(negedge clk);
        srst <= 1'b1;
        burst_order <= order;
        p.clear();
        repeat (5) @(negedge clk);
        srst <= 1'b0;
    endtask

    // A four-word write burst and a five-word read burst that wrap in the aligned group, in the strapped order.
    task automatic t_burst();
        op(0, 1, SEL, 1, TOP + 2, 4'h0);
        repeat (3) op(0, 0, SEL, 1, 17'h0, 4'h0);
        op(0, 1, SEL, 0, TOP + 1, 4'h0);
        repeat (4) op(0, 0, SEL, 0, 17'h0, 4'h0);
        $display("burst test done, order %0d", burst_order);
    endtask

    initial begin
        void'($urandom(99250));
        restart(1'b1);
        // Back-to-back writes then alternating reads and writes at the top of the array.
        for (int i = 0; i < 8; i++) op(0, 1, SEL, 1, TOP + i, 4'h0);
        for (int i = 0; i < 8; i++) begin
            op(0, 1, SEL, 0, TOP + i, 4'h0);
            op(0, 1, SEL, 1, TOP + (7 - i), 4'h0);
        end
        $display("back-to-back test done");
        // Every lane mask, each read back at once.
        for (int m = 0; m < 16; m++) begin
            op(0, 1, SEL, 1, TOP + 3, 4'(m));
            op(0, 1, SEL, 0, TOP + 3, 4'h0);
        end
        $display("lane test done");
        t_burst();
        // Every select pattern with a write command, then an advance and two fresh loads.
        for (int s = 0; s < 8; s++) begin
            op(0, 1, 3'(s), 1, TOP + 4, 4'h0);
            op(0, 0, SEL, 0, 17'h0, 4'h0);
            op(0, 1, SEL, 0, TOP + 4, 4'h0);
            op(0, 1, SEL, 0, TOP + 5, 4'h0);
        end
        $display("select test done");
        // Gated edges between a command and its data, and inside a read burst.
        op(0, 1, SEL, 1, TOP + 6, 4'h0);
        repeat (3) op(1, 0, SEL, 0, 17'h0, 4'h0);
        op(0, 1, SEL, 0, TOP + 6, 4'h0);
        repeat (2) op(1, 0, SEL, 0, 17'h0, 4'h0);
        op(0, 0, SEL, 0, 17'h0, 4'h0);
        $display("gating test done");
        repeat (2) op(0, 1, 3'b000, 0, 17'h0, 4'hF);
        restart(1'b0);
        t_burst();
        repeat (2) op(0, 1, 3'b000, 0, 17'h0, 4'hF);
        // Park the bus a cycle later so the watcher still takes and checks the last note.
        @(negedge clk);
        p.clear();
        repeat (2) @(negedge clk);
        conclude();
    end
endmodule
